// *** edsc_pkg.sv ***
// constants and types of the end device sleep controller
package edsc_pkg;
    // ------------------------------------------------------------
    // modes and options
    // ------------------------------------------------------------
    localparam logic [2:0] MODE_PIN = 3'h1;
    localparam logic [2:0] MODE_CYC = 3'h4;
    localparam logic [2:0] MODE_CYC_PIN = 3'h5;
    localparam int OPT_FULL_HOLD = 1;
    localparam int OPT_EXTENDED = 2;
    localparam logic [11:0] PERIOD_MIN = 12'h020;
    localparam logic [11:0] PERIOD_MAX = 12'haf0;
    localparam logic [15:0] MULT_MIN = 16'h0001;
    localparam logic [15:0] HOLD_MIN = 16'h0001;
    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int CLK_HZ = 10_000_000;
    localparam int TICK_MS = 10;
    localparam int TICK_CYC = CLK_HZ / 1000 * TICK_MS;
    localparam int POLL_MS = 100;
    localparam logic [3:0] POLL_TICKS = 4'(POLL_MS / TICK_MS);
    // ------------------------------------------------------------
    // state types
    // ------------------------------------------------------------
    typedef enum logic [1:0] {ST_AWAKE, ST_DRAIN, ST_SLEEP} edsc_state_t;
    typedef enum logic [1:0] {PL_IDLE, PL_WAIT, PL_RX} edsc_poll_t;
endpackage

// *** edsc_top.sv ***
// sleep and wake sequencer of a wireless network end device
`timescale 1ns/1ns
module edsc_top
    import edsc_pkg::*;
#(
    parameter int TICK_CYCLES = edsc_pkg::TICK_CYC
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic srst_i,
    // configuration
    input wire logic [2:0] sleep_mode_select_i,
    input wire logic flow_control_config_i,
    input wire logic [15:0] channel_mask_i,
    input wire logic [15:0] wake_hold_timer_i,
    input wire logic [11:0] sleep_period_i,
    input wire logic [15:0] period_multiplier_i,
    input wire logic [7:0] sleep_options_i,
    input wire logic force_sleep_i,
    // host pin and data events
    input wire logic sleep_request_pin_i,
    input wire logic serial_rx_i,
    input wire logic radio_rx_i,
    // network status
    input wire logic joined_i,
    input wire logic busy_i,
    input wire logic poll_ack_i,
    input wire logic ack_pending_i,
    // indicators
    output logic awake_o,
    output logic cts_n_o,
    output logic data_accept_o,
    // radio control
    output logic poll_req_o,
    output logic rx_enable_o,
    output logic scan_req_o,
    output logic [15:0] scan_mask_o
);
    import edsc_pkg::*;

    // ------------------------------------------------------------
    // 10 ms tick divider
    // ------------------------------------------------------------
    logic [23:0] tick_cnt;
    logic [23:0] next_tick_cnt;
    logic tick;
    logic next_tick;

    // one tick pulse serves every timer, so no timer needs a wide counter
    always_comb begin
        next_tick = 1'b0;
        next_tick_cnt = tick_cnt + 24'h000001;
        if (tick_cnt >= 24'(TICK_CYCLES - 1)) begin
            next_tick_cnt = '0;
            next_tick = 1'b1;
        end
    end

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            tick_cnt <= '0;
            tick <= 1'b0;
        end else begin
            tick_cnt <= next_tick_cnt;
            tick <= next_tick;
        end
    end

    // ------------------------------------------------------------
    // sleep sequencer
    // ------------------------------------------------------------
    edsc_state_t state, next_state;
    edsc_poll_t poll_st, next_poll_st;
    logic [3:0] poll_cnt, next_poll_cnt;
    logic [15:0] hold_cnt, next_hold_cnt;
    logic hold_run, next_hold_run;
    logic [11:0] per_cnt, next_per_cnt;
    logic [15:0] mult_cnt, next_mult_cnt;
    logic [15:0] cyc_cnt, next_cyc_cnt;
    logic pin_q;
    logic next_awake, next_cts_n, next_accept, next_poll_req, next_rx_en;
    logic next_scan_req;
    logic [15:0] next_scan_mask;
    logic pin_mode, cyc_mode, fall, extended, full_hold, go_sleep, wake, pin_wake, raise;
    logic [11:0] per_eff;
    logic [15:0] mult_eff, hold_eff;

    // clamp settings to their legal ranges
    // period range clamp
    assign per_eff = (sleep_period_i < PERIOD_MIN) ? PERIOD_MIN :
                     (sleep_period_i > PERIOD_MAX) ? PERIOD_MAX : sleep_period_i;
    assign mult_eff = (period_multiplier_i < MULT_MIN) ? MULT_MIN : period_multiplier_i;
    assign hold_eff = (wake_hold_timer_i < HOLD_MIN) ? HOLD_MIN : wake_hold_timer_i;
    assign pin_mode = (sleep_mode_select_i == MODE_PIN);
    assign cyc_mode = (sleep_mode_select_i == MODE_CYC) || (sleep_mode_select_i == MODE_CYC_PIN);
    assign extended = sleep_options_i[OPT_EXTENDED];
    assign full_hold = sleep_options_i[OPT_FULL_HOLD];
    // pin_q is a plain history flop, pins are synchronous already
    assign fall = pin_q && !sleep_request_pin_i;

    always_comb begin
        next_state = state;
        next_poll_st = poll_st;
        next_poll_cnt = poll_cnt;
        next_hold_cnt = hold_cnt;
        next_hold_run = hold_run;
        next_per_cnt = per_cnt;
        next_mult_cnt = mult_cnt;
        next_cyc_cnt = cyc_cnt;
        next_awake = awake_o;
        next_cts_n = cts_n_o;
        next_accept = data_accept_o;
        next_rx_en = rx_enable_o;
        next_poll_req = 1'b0;
        next_scan_req = 1'b0;
        next_scan_mask = scan_mask_o;
        go_sleep = 1'b0;
        wake = 1'b0;
        pin_wake = 1'b0;
        raise = 1'b0;
        unique case (state)
            ST_AWAKE: begin
                if (tick) begin
                    next_poll_cnt = poll_cnt + 4'h1;
                    if (poll_cnt >= POLL_TICKS - 4'h1) begin
                        next_poll_cnt = '0;
                        if (joined_i) begin
                            next_poll_req = 1'b1;
                            next_rx_en = 1'b1;
                            next_poll_st = PL_WAIT;
                        end
                    end
                end
                if (poll_st == PL_WAIT && poll_ack_i) begin
                    next_poll_st = ack_pending_i ? PL_RX : PL_IDLE;
                    next_rx_en = ack_pending_i;
                    // parent data starts the hold timer
                    if (cyc_mode && ack_pending_i) begin
                        next_hold_run = 1'b1;
                        next_hold_cnt = hold_eff;
                    end
                    // nothing pending and no timer: sleep at once
                    if (cyc_mode && !ack_pending_i && !hold_run) begin
                        go_sleep = 1'b1;
                    end
                end
                if (hold_run && tick) begin
                    next_hold_cnt = hold_cnt - 16'h0001;
                    if (hold_cnt <= HOLD_MIN) begin
                        go_sleep = 1'b1;
                    end
                end
                if (cyc_mode && (serial_rx_i || radio_rx_i)) begin
                    next_hold_run = 1'b1;
                    next_hold_cnt = hold_eff;
                    go_sleep = 1'b0;
                end
                // radio data ends silent polling at once
                if (radio_rx_i && !awake_o) begin
                    next_awake = 1'b1;
                    next_cts_n = 1'b0;
                    next_cyc_cnt = '0;
                end
                if (cyc_mode && force_sleep_i) begin
                    go_sleep = 1'b1;
                end
                if (pin_mode && sleep_request_pin_i) begin
                    next_state = ST_DRAIN;
                end
            end
            ST_DRAIN: begin
                if (!sleep_request_pin_i) begin
                    next_state = ST_AWAKE;
                end else if (!busy_i) begin
                    go_sleep = 1'b1;
                end
            end
            ST_SLEEP: begin
                if (pin_mode) begin
                    pin_wake = !sleep_request_pin_i;
                end else if (cyc_mode) begin
                    // early wake on falling pin in mode 5 only
                    if (sleep_mode_select_i == MODE_CYC_PIN && fall) begin
                        pin_wake = 1'b1;
                    end
                    if (tick) begin
                        next_per_cnt = per_cnt + 12'h001;
                        if (per_cnt >= per_eff - 12'h001) begin
                            next_per_cnt = '0;
                            if (extended && mult_cnt + 16'h0001 < mult_eff) begin
                                next_mult_cnt = mult_cnt + 16'h0001;
                            end else begin
                                // short sleep wakes after one period
                                wake = 1'b1;
                            end
                        end
                    end
                end else begin
                    pin_wake = 1'b1;
                end
                wake = wake || pin_wake;
            end
            default: begin
                next_state = ST_AWAKE;
            end
        endcase
        if (go_sleep) begin
            next_state = ST_SLEEP;
            // indicator low, CTS high under flow control
            next_awake = 1'b0;
            next_cts_n = flow_control_config_i;
            next_accept = 1'b0;
            next_rx_en = 1'b0;
            // a poll slot landing on the sleep edge is dropped, never sent while asleep
            next_poll_req = 1'b0;
            next_poll_st = PL_IDLE;
            next_hold_run = 1'b0;
            next_per_cnt = '0;
            next_mult_cnt = '0;
        end
        if (wake) begin
            next_state = ST_AWAKE;
            next_accept = 1'b1;
            next_poll_cnt = '0;
            next_poll_req = joined_i;
            next_rx_en = joined_i;
            next_poll_st = joined_i ? PL_WAIT : PL_IDLE;
            // unjoined wake scans the channel mask
            next_scan_req = !joined_i;
            next_scan_mask = channel_mask_i;
            // full hold option keeps it up for the whole hold time
            if (cyc_mode && full_hold) begin
                next_hold_run = 1'b1;
                next_hold_cnt = hold_eff;
            end
            // indicator on pin, non-cyclic or extended wakes, else after the wake count
            raise = pin_wake || !cyc_mode || extended || (cyc_cnt + 16'h0001 >= mult_eff);
            if (raise) begin
                next_awake = 1'b1;
                next_cts_n = 1'b0;
                next_cyc_cnt = '0;
            end else begin
                next_cyc_cnt = cyc_cnt + 16'h0001;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            state <= ST_AWAKE;
            poll_st <= PL_IDLE;
            poll_cnt <= '0;
            hold_cnt <= '0;
            hold_run <= 1'b0;
            per_cnt <= '0;
            mult_cnt <= '0;
            cyc_cnt <= '0;
            pin_q <= 1'b0;
            awake_o <= 1'b1;
            cts_n_o <= 1'b0;
            data_accept_o <= 1'b1;
            poll_req_o <= 1'b0;
            rx_enable_o <= 1'b0;
            scan_req_o <= 1'b0;
            scan_mask_o <= '0;
        end else begin
            state <= next_state;
            poll_st <= next_poll_st;
            poll_cnt <= next_poll_cnt;
            hold_cnt <= next_hold_cnt;
            hold_run <= next_hold_run;
            per_cnt <= next_per_cnt;
            mult_cnt <= next_mult_cnt;
            cyc_cnt <= next_cyc_cnt;
            pin_q <= sleep_request_pin_i;
            awake_o <= next_awake;
            cts_n_o <= next_cts_n;
            data_accept_o <= next_accept;
            poll_req_o <= next_poll_req;
            rx_enable_o <= next_rx_en;
            scan_req_o <= next_scan_req;
            scan_mask_o <= next_scan_mask;
        end
    end

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    default clocking @(posedge clk_i); endclocking
    default disable iff (srst_i);

    sleep_ind_a: assert property (state == ST_SLEEP |-> !awake_o)
        else $error("indicator high while asleep");
    sleep_cts_a: assert property (state == ST_SLEEP && $past(state) != ST_SLEEP
        |-> cts_n_o == $past(flow_control_config_i))
        else $error("cts wrong on sleep entry");
    wake_ind_a: assert property ($past(state) == ST_SLEEP && state == ST_AWAKE
        && $past(period_multiplier_i) == 16'h0001 |-> awake_o && !cts_n_o)
        else $error("indicator not raised on wake");
    no_accept_a: assert property (state == ST_SLEEP |-> !data_accept_o)
        else $error("data accepted while asleep");
    no_poll_sleep_a: assert property (state == ST_SLEEP |-> !poll_req_o)
        else $error("poll sent while asleep");
    poll_rx_a: assert property (poll_req_o |-> rx_enable_o ##1 rx_enable_o)
        else $error("receiver off after poll");
    drain_hold_a: assert property (state == ST_DRAIN && busy_i |=> state != ST_SLEEP)
        else $error("slept while busy");
    pin_wake_a: assert property (state == ST_SLEEP && pin_mode && !sleep_request_pin_i
        |=> state == ST_AWAKE)
        else $error("no wake on low pin");
    mode4_a: assert property (state == ST_SLEEP && sleep_mode_select_i == MODE_CYC && !tick
        |=> state == ST_SLEEP)
        else $error("mode 4 woke early");
    force_a: assert property (state == ST_AWAKE && cyc_mode && force_sleep_i
        |=> state == ST_SLEEP)
        else $error("force sleep ignored");
    scan_a: assert property ($past(state) == ST_SLEEP && state == ST_AWAKE
        && !$past(joined_i) |-> scan_req_o)
        else $error("no scan on unjoined wake");

    enter_sleep_c: cover property (state == ST_AWAKE ##1 state == ST_SLEEP);
    drain_c: cover property (state == ST_DRAIN ##1 state == ST_SLEEP);
    silent_c: cover property (state == ST_AWAKE && !awake_o ##1 awake_o);
endmodule // edsc_top

// *** edsc_parent_model.sv ***
// parent node model that answers the end device poll requests
`timescale 1ns/1ns
// ------------------------------------------------------------
// poll answer
// ------------------------------------------------------------
module edsc_parent_model (
    // clock
    input wire logic clk_i,
    // behaviour chosen by the bench
    input wire logic slow_i,
    input wire logic pending_i,
    // poll side
    input wire logic poll_req_i,
    output logic poll_ack_o,
    output logic ack_pending_o
);
    int wait_cnt = 0;
    initial poll_ack_o = 1'b0;
    initial ack_pending_o = 1'b0;
    // ack follows each poll
    // pending is only valid with the ack, so it shows the inverse in between
    // to expose a design that samples it outside the ack cycle
    always @(posedge clk_i) begin
        poll_ack_o <= 1'b0;
        ack_pending_o <= ~pending_i;
        if (poll_req_i) begin
            wait_cnt <= slow_i ? 60 : 2;
        end else if (wait_cnt == 1) begin
            poll_ack_o <= 1'b1;
            ack_pending_o <= pending_i;
            wait_cnt <= 0;
        end else if (wait_cnt > 1) begin
            wait_cnt <= wait_cnt - 1;
        end
    end
endmodule // edsc_parent_model

// *** edsc_tb.sv ***
// self-checking bench of the end device sleep controller
`timescale 1ns/1ns
module testbench;
    import edsc_pkg::*;
    localparam int TICK = 10;
    logic clk_i = 1'b0;
    logic srst_i = 1'b1;
    logic [2:0] mode = MODE_PIN;
    logic [15:0] mask = 16'h5a3c;
    logic [15:0] hold = 16'h0008;
    logic [11:0] period = 12'h001;
    logic [15:0] mult = 16'h0000;
    logic [7:0] opts = 8'h00;
    logic flow = 1'b1, force_sl = 1'b0, pin = 1'b0, ser = 1'b0, rad = 1'b0;
    logic joined = 1'b1, busy = 1'b0, slow = 1'b0, pend = 1'b0, ack, ack_pend;
    logic awake_o, cts_n_o, data_accept_o, poll_req_o, rx_enable_o, scan_req_o;
    logic [15:0] scan_mask_o;
    int failures = 0;
    int comparisons = 0;
    int n;
    // ------------------------------------------------------------
    // design and far side
    // ------------------------------------------------------------
    edsc_top #(.TICK_CYCLES(TICK)) dut (.clk_i(clk_i), .srst_i(srst_i),
        .sleep_mode_select_i(mode), .flow_control_config_i(flow), .channel_mask_i(mask),
        .wake_hold_timer_i(hold), .sleep_period_i(period), .period_multiplier_i(mult),
        .sleep_options_i(opts), .force_sleep_i(force_sl), .sleep_request_pin_i(pin),
        .serial_rx_i(ser), .radio_rx_i(rad), .joined_i(joined), .busy_i(busy),
        .poll_ack_i(ack), .ack_pending_i(ack_pend), .awake_o(awake_o), .cts_n_o(cts_n_o),
        .data_accept_o(data_accept_o), .poll_req_o(poll_req_o), .rx_enable_o(rx_enable_o),
        .scan_req_o(scan_req_o), .scan_mask_o(scan_mask_o));
    edsc_parent_model parent (.clk_i(clk_i), .slow_i(slow), .pending_i(pend),
        .poll_req_i(poll_req_o), .poll_ack_o(ack), .ack_pending_o(ack_pend));
    initial begin
        forever #50 clk_i = ~clk_i;
    end
    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        comparisons++;
        if (seen !== exp) begin
            failures++;
            $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic report_and_stop();
        $display("comparisons %0d failures %0d", comparisons, failures);
        if (failures == 0 && comparisons > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    task automatic step(input int k);
        repeat (k) @(negedge clk_i);
    endtask
    // bounded wait for the accept flag; a run-out counts as a mismatch
    task automatic wait_accept(input logic lvl, input int limit, output int cnt);
        cnt = 0;
        while (data_accept_o !== lvl && cnt < limit) begin
            @(negedge clk_i);
            cnt++;
        end
        if (cnt >= limit) begin
            failures++;
            $display("mismatch at %0t: accept flag wait ran out", $time);
        end
    endtask
    // cycles from this call up to the next poll pulse
    task automatic wait_poll(output int cnt);
        cnt = 0;
        do begin
            @(negedge clk_i);
            cnt++;
        end while (poll_req_o !== 1'b1 && cnt < 300);
        if (cnt >= 300) begin
            failures++;
            $display("mismatch at %0t: no poll seen", $time);
        end
    endtask
    // one-cycle event pulse: 0 serial, 1 radio, 2 force sleep
    task automatic pulse(input int sel);
        @(posedge clk_i);
        ser <= (sel == 0);
        rad <= (sel == 1);
        force_sl <= (sel == 2);
        @(posedge clk_i);
        {ser, rad, force_sl} <= 3'h0;
        @(negedge clk_i);
    endtask
    // host holds serial data back while cts is high
    task automatic send_serial();
        while (cts_n_o !== 1'b0) @(negedge clk_i);
        pulse(0);
    endtask
    // ------------------------------------------------------------
    // test sequence
    // ------------------------------------------------------------
    initial begin
        repeat (6) @(posedge clk_i);
        srst_i <= 1'b0;
        step(1);
        check({awake_o, cts_n_o, data_accept_o, rx_enable_o}, 4'ha);
        check(scan_mask_o, 16'h0000);
        wait_poll(n);
        wait_poll(n);
        wait_poll(n);
        check(16'(n), 16'(10 * TICK));
        // a slow ack must keep the receiver open the whole time
        @(posedge clk_i);
        slow <= 1'b1;
        wait_poll(n);
        step(30);
        check(rx_enable_o, 1'b1);
        step(36);
        check(rx_enable_o, 1'b0);
        @(posedge clk_i);
        slow <= 1'b0;
        pend <= 1'b1;
        wait_poll(n);
        step(6);
        check(rx_enable_o, 1'b1);
        // pin sleep waits for the busy network activity
        @(posedge clk_i);
        pend <= 1'b0;
        busy <= 1'b1;
        pin <= 1'b1;
        step(20);
        check(data_accept_o, 1'b1);
        @(posedge clk_i);
        busy <= 1'b0;
        wait_accept(1'b0, 10, n);
        check({awake_o, cts_n_o, rx_enable_o}, 3'b010);
        pulse(0);
        pulse(1);
        step(4);
        check({awake_o, data_accept_o, poll_req_o}, 3'b000);
        // host lowers the request to wake an unjoined device
        @(posedge clk_i);
        joined <= 1'b0;
        pin <= 1'b0;
        wait_accept(1'b1, 5, n);
        check({awake_o, cts_n_o, scan_req_o}, 3'b101);
        check(scan_mask_o, mask);
        @(posedge clk_i);
        joined <= 1'b1;
        flow <= 1'b0;
        pin <= 1'b1;
        wait_accept(1'b0, 10, n);
        check({awake_o, cts_n_o}, 2'b00);
        @(posedge clk_i);
        pin <= 1'b0;
        wait_accept(1'b1, 5, n);
        @(posedge clk_i);
        mode <= MODE_CYC;
        flow <= 1'b1;
        wait_accept(1'b0, 150, n);
        wait_accept(1'b1, 400, n);
        // period 0x001 is raised to 0x20 ticks; tick phase takes off up to one tick
        check(16'(n >= 31 * TICK && n <= 33 * TICK), 16'h1);
        check({awake_o, cts_n_o}, 2'b10);
        wait_accept(1'b0, 10, n);
        check(16'(n < 8), 16'h1);
        @(posedge clk_i);
        pin <= 1'b1;
        @(posedge clk_i);
        pin <= 1'b0;
        step(5);
        check(data_accept_o, 1'b0);
        @(posedge clk_i);
        mode <= MODE_CYC_PIN;
        pin <= 1'b1;
        pend <= 1'b1;
        @(posedge clk_i);
        pin <= 1'b0;
        wait_accept(1'b1, 3, n);
        check(data_accept_o, 1'b1);
        // serial data reloads the hold timer started by pending parent data
        step(10);
        @(posedge clk_i);
        pend <= 1'b0;
        step(45);
        send_serial();
        step(55);
        check(data_accept_o, 1'b1);
        wait_accept(1'b0, 40, n);
        check({awake_o, cts_n_o}, 2'b01);
        @(posedge clk_i);
        pend <= 1'b1;
        pin <= 1'b1;
        @(posedge clk_i);
        pin <= 1'b0;
        wait_accept(1'b1, 3, n);
        step(10);
        pulse(2);
        step(2);
        check(data_accept_o, 1'b0);
        // silent polling with a multiplier of two
        @(posedge clk_i);
        pend <= 1'b0;
        slow <= 1'b1;
        mult <= 16'h0002;
        wait_accept(1'b1, 400, n);
        check(awake_o, 1'b0);
        pulse(1);
        step(1);
        check(awake_o, 1'b1);
        pulse(2);
        wait_accept(1'b0, 5, n);
        wait_accept(1'b1, 400, n);
        check(awake_o, 1'b0);
        wait_accept(1'b0, 100, n);
        wait_accept(1'b1, 400, n);
        check(awake_o, 1'b1);
        @(posedge clk_i);
        opts <= 8'h04;
        wait_accept(1'b0, 100, n);
        wait_accept(1'b1, 800, n);
        check(16'(n >= 63 * TICK && n <= 65 * TICK), 16'h1);
        check(awake_o, 1'b1);
        // full hold keeps a silent wake up for the whole hold time
        @(posedge clk_i);
        opts <= 8'h02;
        slow <= 1'b0;
        wait_accept(1'b0, 100, n);
        wait_accept(1'b1, 400, n);
        wait_accept(1'b0, 100, n);
        check(16'(n), 16'(8 * TICK));
        // selectors other than pin or cyclic never keep the device asleep
        @(posedge clk_i);
        mode <= 3'h0;
        wait_accept(1'b1, 5, n);
        check({awake_o, cts_n_o}, 2'b10);
        report_and_stop();
    end
    // hang guard well beyond the few thousand cycles the tests need
    initial begin
        repeat (20000) @(posedge clk_i);
        failures++;
        report_and_stop();
    end
endmodule // testbench
